// ### common/mss_pkg.sv
// Package: constants and state type of the mirror array supply sequencer
package mss_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ = 200;
	localparam int OFFSET_BIAS_DELAY_MS = 2;
	localparam int OFFSET_BIAS_DELAY_CYC = OFFSET_BIAS_DELAY_MS * 1000 * CLK_MHZ;
	localparam int CNT_W = 24;
	// Settle and discharge indications must persist this many cycles
	localparam int FILT_CYC = 4;
	localparam int FILT_W = 3;
	// Park wait limit, counted in the same counter
	localparam int PARK_TIMEOUT_MS = 10;
	localparam int PARK_TIMEOUT_CYC = PARK_TIMEOUT_MS * 1000 * CLK_MHZ;

	// ----------------------------------------
	// Sequencer states
	// ----------------------------------------
	typedef enum logic [8:0] {
		MSS_OFF = 9'h001,
		MSS_LOGIC_UP = 9'h002,
		MSS_OFFSET_UP = 9'h004,
		MSS_BIAS_WAIT = 9'h008,
		MSS_HV_UP = 9'h010,
		MSS_RUN = 9'h020,
		MSS_PARK = 9'h040,
		MSS_HV_DOWN = 9'h080,
		MSS_LOGIC_DOWN = 9'h100
	} mss_state_t;
endpackage

// ### logic/mss_sequencer.sv
// Module: power-up and power-down sequencer for a micromirror array
//
// Operation
// - Core and io supplies settle before HV rails
// - Bias-offset delta held in limit on power-up
// - Low-speed inputs held low until logic settled
// - Reset rail timing free versus offset, bias
// - Reverse order; logic held until HV below 4V
// - Bias before offset optional; delta still limited
// - Low-speed inputs below io level on power-down
// - Bias starts at least 2 ms after offset
// - Offset, bias below 6 V around the delay
// - Offset first up, bias first down
// - Bias-reset delta always within limit
// - On power loss in run park, then drop HV rails
`timescale 1ns/1ps
module mss_sequencer #(
	// Timing counts; a bench may shorten them to keep runs small
	parameter int DELAY_CYC = mss_pkg::OFFSET_BIAS_DELAY_CYC,
	parameter int PARK_CYC = mss_pkg::PARK_TIMEOUT_CYC
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// System requests
	input wire logic power_on_req,
	input wire logic power_fail,
	input wire logic park_done,
	// Supply indications from pins
	input wire logic logic_good_raw,
	input wire logic offset_good_raw,
	input wire logic bias_good_raw,
	input wire logic reset_good_raw,
	input wire logic hv_discharged_raw,
	// Supply enables
	output logic core_supply_en,
	output logic io_supply_en,
	output logic offset_supply_en,
	output logic bias_supply_en,
	output logic reset_supply_en,
	// Input gating and status
	output logic low_speed_inputs_en,
	output logic park_req,
	output logic power_ready
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [4:0] raw_v, good_v;
	assign raw_v = {hv_discharged_raw, reset_good_raw, bias_good_raw,
		offset_good_raw, logic_good_raw};

	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_sync
			mss_sync_filt u_sync (
				.ref_clk(ref_clk),
				.rst_n(rst_n),
				.raw(raw_v[gi]),
				.level(good_v[gi])
			);
		end
	endgenerate

	logic logic_good, offset_good, bias_good, reset_good, hv_low;
	assign logic_good = good_v[0];
	assign offset_good = good_v[1];
	assign bias_good = good_v[2];
	assign reset_good = good_v[3];
	assign hv_low = good_v[4];

	// ----------------------------------------
	// State machine
	// ----------------------------------------
	mss_pkg::mss_state_t state_q, state_d;
	logic [mss_pkg::CNT_W-1:0] cnt_q, cnt_d;
	logic core_q, core_d, off_q, off_d, bias_q, bias_d, rst_q, rst_d;
	logic lsi_q, lsi_d, park_q, park_d, rdy_q, rdy_d;
	logic stop;

	// Power loss overrides an on request
	assign stop = power_fail || !power_on_req;

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		core_d = core_q;
		off_d = off_q;
		bias_d = bias_q;
		rst_d = rst_q;
		lsi_d = lsi_q;
		park_d = 1'b0;
		rdy_d = 1'b0;
		unique case (state_q)
			mss_pkg::MSS_OFF: begin
				lsi_d = 1'b0;
				if (power_on_req && !power_fail) begin
					core_d = 1'b1;
					state_d = mss_pkg::MSS_LOGIC_UP;
				end
			end
			mss_pkg::MSS_LOGIC_UP: begin
				if (stop) begin
					state_d = mss_pkg::MSS_HV_DOWN;
				end else if (logic_good) begin
					// Offset rail first; reset rail with it, order free
					off_d = 1'b1;
					rst_d = 1'b1;
					lsi_d = 1'b1;
					cnt_d = '0;
					state_d = mss_pkg::MSS_OFFSET_UP;
				end
			end
			mss_pkg::MSS_OFFSET_UP: begin
				// Delay counted from offset enable, rail starts near 0 V
				if (stop) begin
					state_d = mss_pkg::MSS_HV_DOWN;
				end else if (cnt_q ==
					mss_pkg::CNT_W'(DELAY_CYC - 1)) begin
					state_d = mss_pkg::MSS_BIAS_WAIT;
				end else begin
					cnt_d = cnt_q + 1'b1;
				end
			end
			mss_pkg::MSS_BIAS_WAIT: begin
				if (stop) begin
					state_d = mss_pkg::MSS_HV_DOWN;
				end else if (offset_good) begin
					bias_d = 1'b1;
					state_d = mss_pkg::MSS_HV_UP;
				end
			end
			mss_pkg::MSS_HV_UP: begin
				if (stop) begin
					state_d = mss_pkg::MSS_HV_DOWN;
				end else if (bias_good && reset_good) begin
					state_d = mss_pkg::MSS_RUN;
				end
			end
			mss_pkg::MSS_RUN: begin
				rdy_d = !stop;
				if (stop) begin
					cnt_d = '0;
					park_d = 1'b1;
					state_d = mss_pkg::MSS_PARK;
				end
			end
			mss_pkg::MSS_PARK: begin
				park_d = 1'b1;
				cnt_d = cnt_q + 1'b1;
				// Timeout keeps a dead park acknowledge from pinning rails
				if (park_done || cnt_q ==
					mss_pkg::CNT_W'(PARK_CYC - 1)) begin
					park_d = 1'b0;
					state_d = mss_pkg::MSS_HV_DOWN;
				end
			end
			mss_pkg::MSS_HV_DOWN: begin
				// Bias dropped first, then offset and reset together
				lsi_d = 1'b0;
				bias_d = 1'b0;
				if (!bias_q) begin
					off_d = 1'b0;
					rst_d = 1'b0;
					if (!off_q && hv_low) begin
						state_d = mss_pkg::MSS_LOGIC_DOWN;
					end
				end
			end
			mss_pkg::MSS_LOGIC_DOWN: begin
				core_d = 1'b0;
				if (!logic_good) begin
					state_d = mss_pkg::MSS_OFF;
				end
			end
			default: begin
				core_d = core_q;
				off_d = 1'b0;
				bias_d = 1'b0;
				rst_d = 1'b0;
				lsi_d = 1'b0;
				state_d = mss_pkg::MSS_HV_DOWN;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= mss_pkg::MSS_OFF;
			cnt_q <= '0;
			core_q <= 1'b0;
			off_q <= 1'b0;
			bias_q <= 1'b0;
			rst_q <= 1'b0;
			lsi_q <= 1'b0;
			park_q <= 1'b0;
			rdy_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			core_q <= core_d;
			off_q <= off_d;
			bias_q <= bias_d;
			rst_q <= rst_d;
			lsi_q <= lsi_d;
			park_q <= park_d;
			rdy_q <= rdy_d;
		end
	end

	assign core_supply_en = core_q;
	assign io_supply_en = core_q;
	assign offset_supply_en = off_q;
	assign bias_supply_en = bias_q;
	assign reset_supply_en = rst_q;
	assign low_speed_inputs_en = lsi_q;
	assign park_req = park_q;
	assign power_ready = rdy_q;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	// Helper: cycles since offset enable rose
	logic [mss_pkg::CNT_W-1:0] since_off_q;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			since_off_q <= '0;
		end else if (!off_q) begin
			since_off_q <= '0;
		end else if (since_off_q != '1) begin
			since_off_q <= since_off_q + 1'b1;
		end
	end

	a_hv_after_logic: assert property (
		$rose(off_q) |-> core_q && $past(logic_good))
		else $error("Offset rail enabled before logic settled");
	a_lsi_gated: assert property (
		lsi_q |-> core_q && (off_q || state_q == mss_pkg::MSS_LOGIC_UP))
		else $error("Low-speed inputs driven without logic supply");
	a_logic_held_down: assert property (
		$fell(core_q) |-> !off_q && !bias_q && !rst_q && $past(hv_low))
		else $error("Logic supply removed before HV discharged");
	a_bias_delay: assert property (
		$rose(bias_q) |-> since_off_q >=
			mss_pkg::CNT_W'(DELAY_CYC))
		else $error("Bias enabled before offset delay elapsed");
	a_bias_needs_off: assert property (
		bias_q |-> off_q)
		else $error("Bias on without offset");
	a_bias_reset_pair: assert property (
		$rose(bias_q) |-> rst_q)
		else $error("Bias raised without reset rail");
	a_park_before_hv: assert property (
		state_q == mss_pkg::MSS_RUN && stop |=> park_q && bias_q)
		else $error("HV dropped without park request");
	a_down_order: assert property (
		$fell(off_q) |-> $past(!bias_q))
		else $error("Offset dropped before bias");
	a_lsi_down: assert property (
		state_q == mss_pkg::MSS_HV_DOWN |=> !lsi_q)
		else $error("Low-speed inputs high during power-down");

	c_reach_run: cover property (state_q == mss_pkg::MSS_RUN);
	c_park_done: cover property (park_q ##1 state_q == mss_pkg::MSS_HV_DOWN);
	c_full_off: cover property ($fell(core_q));
	c_park_timeout: cover property (park_q && !park_done ##1 !park_q);
	c_abort_up: cover property (
		state_q == mss_pkg::MSS_OFFSET_UP ##1 state_q == mss_pkg::MSS_HV_DOWN);
endmodule

// ### logic/mss_sync_filt.sv
// Module: two-flop synchroniser with a persistence filter
`timescale 1ns/1ps
module mss_sync_filt (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Raw pin and filtered level
	input wire logic raw,
	output logic level
);
	logic meta_q, sync_q, level_q, level_d;
	logic [mss_pkg::FILT_W-1:0] cnt_q, cnt_d;

	always_comb begin
		cnt_d = cnt_q;
		level_d = level_q;
		if (sync_q == level_q) begin
			cnt_d = '0;
		end else if (cnt_q == mss_pkg::FILT_W'(mss_pkg::FILT_CYC - 1)) begin
			cnt_d = '0;
			level_d = sync_q;
		end else begin
			cnt_d = cnt_q + 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			level_q <= 1'b0;
			cnt_q <= '0;
		end else begin
			meta_q <= raw;
			sync_q <= meta_q;
			level_q <= level_d;
			cnt_q <= cnt_d;
		end
	end

	assign level = level_q;
endmodule

// ### tb/mss_sequencer_tb.sv
// Self-checking bench for the mirror array supply sequencer
`timescale 1ns/1ps
module mss_sequencer_tb;
	logic ref_clk = 1'h0;
	logic rst_n = 1'h0;
	logic power_on_req = 1'h0;
	logic power_fail = 1'h0;
	logic park_done = 1'h0;
	logic core_en, io_en, ofs_en, bias_en, rst_en, lsi_en, park_req, ready;
	logic lg, og, bg, rg, hv_low, bad;
	int fail_count = 0;
	int check_count = 0;
	int n;
	// Short timing counts keep the run small; hardware keeps 2 ms and 10 ms
	localparam int DELAY_CYC = 2000;
	localparam int PARK_CYC = 300;
	// ----------------------------------------
	// Clock, rail model and sequencer
	// ----------------------------------------
	initial begin
		forever #2.5 ref_clk = ~ref_clk;
	end
	mss_supply_model model_u (.ref_clk(ref_clk), .core_en(core_en),
		.io_en(io_en), .ofs_en(ofs_en), .bias_en(bias_en), .rst_en(rst_en),
		.lg(lg), .og(og), .bg(bg), .rg(rg), .hv_low(hv_low));
	mss_sequencer #(.DELAY_CYC(DELAY_CYC), .PARK_CYC(PARK_CYC)) dut_u (
		.ref_clk(ref_clk), .rst_n(rst_n),
		.power_on_req(power_on_req), .power_fail(power_fail),
		.park_done(park_done), .logic_good_raw(lg), .offset_good_raw(og),
		.bias_good_raw(bg), .reset_good_raw(rg), .hv_discharged_raw(hv_low),
		.core_supply_en(core_en), .io_supply_en(io_en),
		.offset_supply_en(ofs_en), .bias_supply_en(bias_en),
		.reset_supply_en(rst_en), .low_speed_inputs_en(lsi_en),
		.park_req(park_req), .power_ready(ready));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input string what, input logic seen, input logic exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %b, seen %b", what, exp, seen);
		end
	endtask
	task automatic tick();
		@(posedge ref_clk);
		#1;
	endtask
	task automatic final_report();
		if (fail_count == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic wait_offset();
		n = 0;
		while (ofs_en !== 1'h1 && n < 200) begin
			check("hv or lsi early", rst_en | lsi_en | bias_en, 1'h0);
			tick();
			n++;
		end
		check("logic settled first", lg, 1'h1);
		check("lsi released", lsi_en, 1'h1);
		check("bias not first", bias_en, 1'h0);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic test_abort();
		@(posedge ref_clk);
		power_on_req <= 1'h1;
		wait_offset();
		repeat (100) tick();
		@(posedge ref_clk);
		power_on_req <= 1'h0;
		bad = 1'h0;
		n = 0;
		while (core_en === 1'h1 && n < 500) begin
			bad = bad | park_req | bias_en;
			tick();
			n++;
		end
		check("park or bias on abort", bad, 1'h0);
		check("discharged before logic", hv_low, 1'h1);
		check("logic off", core_en | io_en, 1'h0);
		repeat (100) tick();
	endtask
	task automatic test_power_up();
		@(posedge ref_clk);
		power_on_req <= 1'h1;
		wait_offset();
		n = 0;
		while (bias_en !== 1'h1 && n < DELAY_CYC + 200) begin
			tick();
			n++;
		end
		check("bias delay", n >= DELAY_CYC, 1'h1);
		// 2 ms at a 5 ns period
		check("delay constant", mss_pkg::OFFSET_BIAS_DELAY_CYC ==
			2_000_000 / 5, 1'h1);
		check("bias up", bias_en, 1'h1);
		n = 0;
		while (ready !== 1'h1 && n < 200) begin
			tick();
			n++;
		end
		check("ready", ready & lsi_en & rst_en, 1'h1);
	endtask
	task automatic test_power_fail();
		@(posedge ref_clk);
		power_fail <= 1'h1;
		repeat (3) tick();
		check("park asked", park_req, 1'h1);
		check("ready dropped", ready, 1'h0);
		repeat (50) tick();
		check("hv held in park", bias_en & ofs_en & rst_en, 1'h1);
		@(posedge ref_clk);
		park_done <= 1'h1;
		n = 0;
		while (bias_en === 1'h1 && n < 20) begin
			tick();
			n++;
		end
		check("bias off", bias_en, 1'h0);
		check("lsi off with bias", lsi_en, 1'h0);
		check("offset after bias", ofs_en, 1'h1);
		check("logic held", core_en & io_en, 1'h1);
		n = 0;
		while (core_en === 1'h1 && n < 500) begin
			tick();
			n++;
		end
		check("discharged before logic", hv_low, 1'h1);
		check("all off", core_en | ofs_en | rst_en | park_req, 1'h0);
		@(posedge ref_clk);
		power_fail <= 1'h0;
		park_done <= 1'h0;
		power_on_req <= 1'h0;
	endtask
	task automatic test_park_timeout();
		@(posedge ref_clk);
		power_on_req <= 1'h1;
		wait_offset();
		n = 0;
		while (ready !== 1'h1 && n < DELAY_CYC + 400) begin
			tick();
			n++;
		end
		check("ready again", ready, 1'h1);
		@(posedge ref_clk);
		power_on_req <= 1'h0;
		repeat (2) tick();
		n = 0;
		while (park_req === 1'h1 && n < PARK_CYC + 50) begin
			check("hv held until timeout", bias_en & ofs_en, 1'h1);
			tick();
			n++;
		end
		// One cycle of the park window passes before the loop starts
		check("park timeout", n == PARK_CYC - 1, 1'h1);
		n = 0;
		while (core_en === 1'h1 && n < 500) begin
			tick();
			n++;
		end
		check("discharged before logic", hv_low, 1'h1);
		check("down after timeout",
			core_en | ofs_en | bias_en | rst_en, 1'h0);
	endtask
	// ----------------------------------------
	// Sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'h1;
		tick();
		check("outputs after reset", |{core_en, io_en, ofs_en, bias_en,
			rst_en, lsi_en, park_req, ready}, 1'h0);
		test_abort();
		test_power_up();
		test_power_fail();
		test_park_timeout();
		final_report();
	end
	// All scenarios take about 5000 cycles; allow four times that
	initial begin
		#100_000;
		fail_count++;
		final_report();
	end
endmodule

// ### tb/mss_supply_model.sv
// Rail and settle model of the micromirror array supplies
`timescale 1ns/1ps
module mss_supply_model #(
	parameter int SETTLE = 20
) (
	// Clock
	input wire logic ref_clk,
	// Rail enables
	input wire logic core_en,
	input wire logic io_en,
	input wire logic ofs_en,
	input wire logic bias_en,
	input wire logic rst_en,
	// Rail indications
	output logic lg,
	output logic og,
	output logic bg,
	output logic rg,
	output logic hv_low
);
	int lc = 0;
	int oc = 0;
	int bc = 0;
	int rc = 0;
	// ----------------------------------------
	// Rails
	// ----------------------------------------
	// Ramp while enabled, bleed off at the same rate when not
	function automatic int ramp(input int c, input logic en);
		if (en === 1'h1) return (c < SETTLE) ? c + 1 : c;
		return (c > 0) ? c - 1 : 0;
	endfunction
	always @(posedge ref_clk) begin
		lc <= ramp(lc, core_en & io_en);
		oc <= ramp(oc, ofs_en);
		bc <= ramp(bc, bias_en);
		rc <= ramp(rc, rst_en);
	end
	assign lg = lc == SETTLE;
	assign og = oc == SETTLE;
	assign bg = bc == SETTLE;
	assign rg = rc == SETTLE;
	// Quarter scale stands for the 4 V discharge level
	assign hv_low = oc < SETTLE / 4 && bc < SETTLE / 4 && rc < SETTLE / 4;
endmodule
